// ---- dv/sas_peer.sv ----
// Peer alarm unit sharing the interconnect line.
// Line sinks to low when nobody drives it.
`timescale 1ns/1ps
module sas_peer #(
    parameter int P_DLY = 100
) (
    // Clock
    input wire logic aclk,
    // Line parties
    input wire logic peer_alarm,
    input wire logic io_out,
    input wire logic io_oe_n,
    // Line and own horn
    output logic io_line,
    output logic peer_horn
);
    int cnt = 0;
    assign io_line = (io_out && !io_oe_n) || peer_alarm;
    always @(posedge aclk) begin
        cnt <= io_line ? cnt + 1 : 0;
        peer_horn <= io_line && cnt >= P_DLY;
    end
endmodule : sas_peer

// ---- dv/sas_props.sv ----
// Concurrent checks on the sequencer pins.
// Bound into sas_top; sees only its ports.
`timescale 1ns/1ps
module sas_props #(
    parameter int P_CYC_STRB = 10,
    parameter int P_CYC_ALRM = 40
) (
    // Clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // Watched pins
    input wire logic smoke_cmp,
    input wire logic hush_start_n,
    input wire logic strobe,
    input wire logic hyst_sel,
    input wire logic reduced_sens,
    input wire logic led_on,
    input wire logic horn_drive_primary,
    input wire logic osc_fast,
    input wire logic io_out,
    input wire logic io_oe_n
);
    int strb_len_r;
    int horn_len_r;
    logic rep_r;
    default clocking @(posedge aclk); endclocking
    default disable iff (!aresetn);
    always_ff @(posedge aclk) begin
        strb_len_r <= strobe ? strb_len_r + 1 : 0;
        horn_len_r <= horn_drive_primary ? horn_len_r + 1 : 0;
        rep_r <= osc_fast && (rep_r || !horn_drive_primary);
    end
    chk_oe_tracks_out: assert property (io_oe_n == !io_out)
        else $error("line enable disagrees with drive");
    chk_strobe_width: assert property ($fell(strobe) |-> strb_len_r == P_CYC_STRB)
        else $error("strobe width wrong");
    chk_hyst_local: assert property (hyst_sel == io_out)
        else $error("hysteresis not tied to local alarm");
    chk_alarm_fast: assert property (hyst_sel |-> osc_fast)
        else $error("local alarm without fast period");
    chk_smoke_trip: assert property ($fell(strobe) && $past(smoke_cmp) && !$past(osc_fast) |-> ##[0:1] hyst_sel)
        else $error("smoke sample did not trip");
    chk_remote_dark: assert property (osc_fast && !hyst_sel |-> !led_on)
        else $error("led lit in remote alarm");
    chk_horn_on_len: assert property ($fell(horn_drive_primary) && rep_r && osc_fast |->
        horn_len_r >= 4 * P_CYC_ALRM - 1 && horn_len_r <= 4 * P_CYC_ALRM + 1)
        else $error("horn burst length wrong");
    chk_hush_reduce: assert property ($fell(hush_start_n) |-> ##[1:3] reduced_sens)
        else $error("hush did not reduce sensitivity");
    cov_local: cover property ($rose(hyst_sel));
    cov_remote: cover property ($rose(osc_fast) && !hyst_sel);
    cov_hush: cover property ($fell(reduced_sens));
endmodule : sas_props

bind sas_top sas_props #(.P_CYC_STRB(P_CYC_STRB), .P_CYC_ALRM(P_CYC_ALRM)) u_sas_props (
    .aclk, .aresetn, .smoke_cmp, .hush_start_n, .strobe, .hyst_sel, .reduced_sens,
    .led_on, .horn_drive_primary, .osc_fast, .io_out, .io_oe_n
);

// ---- dv/tb_top.sv ----
// Self-checking bench for the smoke alarm sequencer.
// Drives register bus, pins, external oscillator and a peer.
`timescale 1ns/1ps
module tb_top;
    import sas_pkg::*;
    logic aclk = 0, aresetn = 0;
    logic [31:0] s_axi_awaddr = 0, s_axi_wdata = 0, s_axi_araddr = 0, s_axi_rdata;
    logic [3:0] s_axi_wstrb = 0;
    logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0, s_axi_arvalid = 0, s_axi_rready = 0;
    logic smoke_cmp = 0, batt_low_cmp = 0, hush_start_n = 1, test_n = 1, osc_in = 0, peer_alarm = 0;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic [1:0] s_axi_bresp, s_axi_rresp;
    logic strobe, hyst_sel, reduced_sens, led_on, horn_drive_primary, osc_fast, io_out, io_oe_n;
    logic io_line, peer_horn, m_batt, osc_en = 0;
    logic [31:0] rnd = 32'h0000_7202;
    int err_total = 0, n_compared = 0, k, k2, oc = 0, nt = 0, nt0;
    wire logic [7:0] obs = {peer_horn, reduced_sens, io_line, led_on, horn_drive_primary, osc_fast, hyst_sel, strobe};
    always #50 aclk = !aclk;
    always @(posedge aclk) begin
        if (osc_en) begin
            oc <= (oc == 19) ? 0 : oc + 1;
            if (oc == 19) begin
                osc_in <= !osc_in;
                nt <= nt + !osc_in;
            end
        end
    end
    sas_top #(.P_CYC_STBY(200), .P_CYC_ALRM(40), .P_CYC_STRB(10), .P_CYC_BLINK(50), .P_CYC_IODLY(100)) u_sas_top (
        .aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
        .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
        .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
        .smoke_cmp, .batt_low_cmp, .strobe, .hyst_sel, .reduced_sens, .hush_start_n, .test_n, .osc_in,
        .led_on, .horn_drive_primary, .osc_fast, .io_in(io_line), .io_out, .io_oe_n);
    sas_peer u_sas_peer (.aclk, .peer_alarm, .io_out, .io_oe_n, .io_line, .peer_horn);
    function automatic logic [31:0] xs(input logic [31:0] x);
        x = x ^ (x << 13);
        x = x ^ (x >> 17);
        return x ^ (x << 5);
    endfunction : xs
    task automatic final_report;
        if (err_total == 0 && n_compared > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask : final_report
    task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
        n_compared++;
        if (got !== exp) begin
            err_total++;
            $display("Error %s expected %h seen %h", nm, exp, got);
        end
    endtask : chk
    task automatic wt(input int b, input logic v, input int lim, output int n);
        n = 0;
        do begin
            @(negedge aclk);
            n++;
        end while (obs[b] !== v && n < lim);
        if (obs[b] !== v) begin
            err_total++;
            $display("Error wait_%0d expected %b seen %b", b, v, obs[b]);
            final_report();
        end
    endtask : wt
    task automatic wr(input logic [31:0] a, input logic [31:0] d, input logic [3:0] s, input logic [1:0] r);
        logic ta, tw, bv;
        int n;
        @(posedge aclk);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_wstrb <= s;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        n = 0;
        do begin
            @(negedge aclk);
            ta = s_axi_awready;
            tw = s_axi_wready;
            bv = s_axi_bvalid;
            if (bv) chk("bresp", r, s_axi_bresp);
            @(posedge aclk);
            if (ta) s_axi_awvalid <= 1'b0;
            if (tw) s_axi_wvalid <= 1'b0;
            if (bv) s_axi_bready <= 1'b0;
            n++;
        end while (!bv && n < 50);
        if (!bv) wt(0, 1'bx, 1, n);
    endtask : wr
    task automatic rd(input logic [31:0] a, input logic [31:0] d, input logic [1:0] r, input string nm);
        logic ta, rv;
        int n;
        @(posedge aclk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        n = 0;
        do begin
            @(negedge aclk);
            ta = s_axi_arready;
            rv = s_axi_rvalid;
            if (rv) chk(nm, {d[29:0], r}, {s_axi_rdata[29:0], s_axi_rresp});
            @(posedge aclk);
            if (ta) s_axi_arvalid <= 1'b0;
            if (rv) s_axi_rready <= 1'b0;
            n++;
        end while (!rv && n < 50);
        if (!rv) wt(0, 1'bx, 1, n);
    endtask : rd
    initial begin
        repeat (6) @(posedge aclk);
        aresetn <= 1'b1;
        rnd = xs(rnd);
        m_batt = rnd[0];
        rd(A_CTRL, 0, RESP_OKAY, "ctrl_reset");
        rd(A_STAT, 0, RESP_OKAY, "stat_reset");
        wr(A_STAT, rnd, rnd[7:4], RESP_OKAY);
        rd(A_STAT, 0, RESP_OKAY, "stat_ro");
        wr(32'h0000_0010, rnd, 4'hF, RESP_SLVERR);
        rd(32'h0000_0010, 0, RESP_SLVERR, "unmapped");
        wt(0, 1, 300, k);
        wt(0, 0, 20, k);
        chk("strobe_width", 10, k);
        wt(0, 1, 300, k2);
        chk("standby_period", 200, k + k2);
        batt_low_cmp <= m_batt;
        wt(4, 1, 5000, k);
        chk("led_strobe", 1, strobe);
        wt(4, 0, 20, k);
        chk("led_width", 10, k);
        wt(4, 1, 5000, k2);
        chk("batt_interval", 24 * 200, k + k2);
        rd(A_STAT, {28'h0, m_batt, 3'h0}, RESP_OKAY, "batt_stat");
        smoke_cmp <= 1'b1;
        wt(1, 1, 300, k);
        chk("fast", 1, osc_fast);
        chk("horn", 1, horn_drive_primary);
        chk("line", 1, io_line);
        wt(7, 1, 200, k);
        rd(A_STAT, {26'h0, 2'h2, m_batt, 3'h1}, RESP_OKAY, "alarm_stat");
        wt(3, 0, 200, k);
        wt(3, 1, 100, k);
        chk("horn_off_len", 80, k);
        wt(3, 0, 200, k);
        chk("horn_on_len", 160, k);
        wt(4, !led_on, 60, k);
        wt(4, !led_on, 60, k);
        chk("led_half", 50, k);
        smoke_cmp <= 1'b0;
        wt(1, 0, 300, k);
        chk("horn_clear", 0, horn_drive_primary);
        peer_alarm <= 1'b1;
        wt(2, 1, 200, k);
        chk("remote_delay", 1, k >= 99 && k <= 103);
        wt(3, 1, 10, k);
        chk("remote_led", 0, led_on);
        rd(A_STAT, {28'h0, m_batt, 3'h2}, RESP_OKAY, "remote_stat");
        peer_alarm <= 1'b0;
        wt(2, 0, 20, k);
        wr(A_CTRL, 32'h0000_0001, 4'h1, RESP_OKAY);
        rd(A_CTRL, 32'h0000_0001, RESP_OKAY, "ctrl_ext");
        osc_en <= 1'b1;
        wt(0, 1, 300, k);
        wt(0, 0, 20, k);
        chk("ext_strobe_width", 10, k);
        wt(0, 1, 60, k2);
        chk("ext_period", 40, k + k2);
        smoke_cmp <= 1'b1;
        wt(1, 1, 100, k);
        wt(0, 1, 60, k);
        wt(0, 0, 20, k);
        hush_start_n <= 1'b0;
        nt0 = nt;
        wt(6, 1, 5, k);
        wt(1, 0, 5, k);
        wt(1, 1, 100, k);
        smoke_cmp <= 1'b0;
        hush_start_n <= 1'b1;
        wt(1, 0, 400, k);
        wt(4, 1, 300, k);
        wt(4, 0, 20, k);
        wt(4, 1, 300, k2);
        chk("timer_led", 1, k + k2 <= 240);
        wt(6, 0, 16000, k);
        chk("hush_len", 1, nt - nt0 >= 367 && nt - nt0 <= 369);
        rd(A_STAT, {28'h0, m_batt, 3'h0}, RESP_OKAY, "hush_end_stat");
        final_report();
    end
endmodule : tb_top

// ---- src/sas_pkg.sv ----
// Constants, types and state layout of the smoke alarm sequencer.
// Assumes a 10 MHz system clock and an AXI4-Lite register bus.
package sas_pkg;
    // Clock and time base
    localparam int CLK_HZ = 10_000_000;
    localparam int CYC_PER_MS = CLK_HZ / 1000;
    localparam int T_STBY_MS = 1670;
    localparam int T_ALRM_MS = 40;
    localparam int T_STRB_MS = 10;
    localparam int T_BLINK_MS = 500;
    localparam int T_IODLY_MS = 3000;
    localparam int CYC_STBY = T_STBY_MS * CYC_PER_MS;
    localparam int CYC_ALRM = T_ALRM_MS * CYC_PER_MS;
    localparam int CYC_STRB = T_STRB_MS * CYC_PER_MS;
    localparam int CYC_BLINK = T_BLINK_MS * CYC_PER_MS;
    localparam int CYC_IODLY = T_IODLY_MS * CYC_PER_MS;
    // Oscillator cycle counts
    localparam int N_BATT = 24;
    localparam int N_TMR_LED = 6;
    localparam int N_HUSH = 368;
    localparam int T_HORN_ON_MS = 160;
    localparam int T_HORN_OFF_MS = 80;
    localparam int N_HORN_ON = T_HORN_ON_MS / T_ALRM_MS;
    localparam int N_HORN_CYC = N_HORN_ON + T_HORN_OFF_MS / T_ALRM_MS;
    localparam int CW = 25;
    // Register map
    localparam logic [31:0] A_CTRL = 32'h0000_0000;
    localparam logic [31:0] A_STAT = 32'h0000_0004;
    localparam int CTRL_EXT_OSC = 0;
    localparam logic [31:0] CTRL_RST = 32'h0000_0000;
    localparam int ST_B_LOCAL = 0;
    localparam int ST_B_REMOTE = 1;
    localparam int ST_B_TIMER = 2;
    localparam int ST_B_BATT = 3;
    localparam int ST_B_TEST = 4;
    localparam int ST_B_HYST = 5;
    localparam logic [1:0] RESP_OKAY = 2'b00;
    localparam logic [1:0] RESP_SLVERR = 2'b10;

    typedef enum logic [1:0] {
        ST_STBY = 2'b00,
        ST_ALRM = 2'b01,
        ST_REMT = 2'b10
    } sas_mode_t;

    typedef struct packed {
        sas_mode_t mode;
        logic [CW-1:0] slow_cnt;
        logic [CW-1:0] fast_cnt;
        logic [CW-1:0] strb_cnt;
        logic [CW-1:0] blink_cnt;
        logic [CW-1:0] io_cnt;
        logic strb;
        logic lb_pulse;
        logic [4:0] batt_cnt;
        logic [2:0] tled_cnt;
        logic [8:0] hush_cnt;
        logic timer_mode;
        logic batt_low;
        logic [2:0] horn_ph;
        logic blink;
        logic led;
        logic horn;
        logic io_drv;
        logic osc_d;
        logic hush_d;
        logic first;
        logic test_mode;
        logic ext_osc;
        logic aw_v;
        logic [31:0] aw_a;
        logic w_v;
        logic [31:0] w_d;
        logic bvalid;
        logic [1:0] bresp;
        logic rvalid;
        logic [31:0] rdata;
        logic [1:0] rresp;
    } sas_state_t;
endpackage : sas_pkg

// ---- src/sas_top.sv ----
// Smoke alarm sequencer: strobe timing, battery check, horn cadence,
// hush timer, interconnect line and an AXI4-Lite register slave.
// Assumes comparator results and pins are synchronous to aclk.
//
// Functional notes
// [RL1] Standby: 1.67 s period, strobe and sample smoke
// [RL2] Comparator high means smoke, low means none
// [RL3] Every 24 cycles pulse LED, check battery
// [RL4] Battery compared during the 10 ms LED pulse
// [RL5] Hysteresis select asserted while smoke detected
// [RL6] Smoke: 40 ms period, horn enabled
// [RL7] Horn cadence 160 ms on, 80 ms off
// [RL8] Resample in off time; stop when clear
// [RL9] In alarm: no battery alarm, LED 1 Hz
// [RL10] Hush falling edge: restart timer, reduce, clear alarm
// [RL11] Timer mode flashes LED every 10 s
// [RL12] Timer mode still alarms at reduced trip
// [RL13] Hush timer runs 368 cycles regardless of alarm
// [RL14] Smoke drives line high; line high sounds after 3 s
// [RL15] Remote alarm keeps LED dark
// [RL16] Reset clears all counters
// [RL17] Test and oscillator low at power-up: battery test
// [RL18] External 2 kHz oscillator drives all timing; only standby and alarm ticks follow it here, blink and line delay use aclk
// [RL19] Strobe stays 10 ms even when accelerated
// [RL20] Hush end restores normal sensitivity and LED rate
//
// The AXI4-Lite slave port and the placing of the registers are this design's own decisions.
`timescale 1ns/1ps
module sas_top
    import sas_pkg::*;
#(
    parameter int P_CYC_STBY = CYC_STBY,
    parameter int P_CYC_ALRM = CYC_ALRM,
    parameter int P_CYC_STRB = CYC_STRB,
    parameter int P_CYC_BLINK = CYC_BLINK,
    parameter int P_CYC_IODLY = CYC_IODLY
) (
    // Clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // AXI4-Lite write
    input wire logic [31:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    // AXI4-Lite read
    input wire logic [31:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    // Analog front end
    input wire logic smoke_cmp,
    input wire logic batt_low_cmp,
    output logic strobe,
    output logic hyst_sel,
    output logic reduced_sens,
    // Pins
    input wire logic hush_start_n,
    input wire logic test_n,
    input wire logic osc_in,
    output logic led_on,
    output logic horn_drive_primary,
    output logic osc_fast,
    // Interconnect line
    input wire logic io_in,
    output logic io_out,
    output logic io_oe_n
);

    sas_state_t s_r;
    sas_state_t s_nxt;

    function automatic logic at_end(input logic [CW-1:0] c, input int lim);
        at_end = (c == CW'(lim - 1));
    endfunction : at_end

    function automatic logic [31:0] merge(input logic [31:0] old_v,
                                          input logic [31:0] new_v,
                                          input logic [3:0] be);
        logic [31:0] r;
        r = old_v;
        for (int i = 0; i < 4; i++) begin
            if (be[i]) begin
                r[8*i +: 8] = new_v[8*i +: 8];
            end
        end
        merge = r;
    endfunction : merge

    logic osc_rise;
    logic slow_tick;
    logic fast_tick;
    logic tick;
    logic alarm;
    logic hush_fall;
    logic strb_end;
    logic [31:0] ctrl_word;
    logic [31:0] stat_word;

    always_comb begin
        s_nxt = s_r;
        // External oscillator and internal dividers
        osc_rise = osc_in && !s_r.osc_d;
        s_nxt.osc_d = osc_in;
        s_nxt.hush_d = hush_start_n;
        hush_fall = s_r.hush_d && !hush_start_n;
        alarm = (s_r.mode != ST_STBY);
        if (at_end(s_r.slow_cnt, P_CYC_STBY)) begin
            s_nxt.slow_cnt = '0;
        end else begin
            s_nxt.slow_cnt = s_r.slow_cnt + 1'b1;
        end
        if (at_end(s_r.fast_cnt, P_CYC_ALRM) || !alarm) begin
            s_nxt.fast_cnt = '0;
        end else begin
            s_nxt.fast_cnt = s_r.fast_cnt + 1'b1;
        end
        if (s_r.ext_osc) begin
            slow_tick = osc_rise; // [RL18]
            fast_tick = osc_rise; // [RL18]
        end else begin
            slow_tick = at_end(s_r.slow_cnt, P_CYC_STBY); // [RL1]
            fast_tick = at_end(s_r.fast_cnt, P_CYC_ALRM);
        end
        tick = alarm ? fast_tick : slow_tick; // [RL6]

        // Strobe: fixed length from aclk, whatever the oscillator
        strb_end = s_r.strb && at_end(s_r.strb_cnt, P_CYC_STRB); // [RL19]
        if (s_r.strb) begin
            s_nxt.strb_cnt = s_r.strb_cnt + 1'b1;
        end
        if (strb_end) begin
            s_nxt.strb = 1'b0;
            s_nxt.lb_pulse = 1'b0;
            s_nxt.strb_cnt = '0;
        end
        if (tick) begin
            s_nxt.strb = 1'b1; // [RL1]
            s_nxt.strb_cnt = '0;
        end

        // Battery check and LED flash in standby
        if (tick && !alarm) begin
            if (s_r.batt_cnt == 5'(N_BATT - 1)) begin
                s_nxt.batt_cnt = '0;
                s_nxt.lb_pulse = 1'b1; // [RL3]
            end else begin
                s_nxt.batt_cnt = s_r.batt_cnt + 1'b1;
            end
            if (s_r.tled_cnt == 3'(N_TMR_LED - 1)) begin
                s_nxt.tled_cnt = '0;
                if (s_r.timer_mode) begin
                    s_nxt.lb_pulse = 1'b1; // [RL11]
                end
            end else begin
                s_nxt.tled_cnt = s_r.tled_cnt + 1'b1;
            end
        end
        if (strb_end && s_r.lb_pulse && !alarm) begin
            s_nxt.batt_low = batt_low_cmp; // [RL4]
        end

        // Horn cadence counter
        if (fast_tick && alarm) begin
            if (s_r.horn_ph == 3'(N_HORN_CYC - 1)) begin
                s_nxt.horn_ph = '0; // [RL7]
            end else begin
                s_nxt.horn_ph = s_r.horn_ph + 1'b1;
            end
        end

        // Alarm blink
        if (alarm && !at_end(s_r.blink_cnt, P_CYC_BLINK)) begin
            s_nxt.blink_cnt = s_r.blink_cnt + 1'b1;
        end else begin
            s_nxt.blink_cnt = '0;
        end
        if (!alarm) begin
            s_nxt.blink = 1'b0;
        end else if (at_end(s_r.blink_cnt, P_CYC_BLINK)) begin
            s_nxt.blink = !s_r.blink; // [RL9]
        end

        // Mode sequencing
        case (s_r.mode)
            ST_STBY: begin
                if (strb_end && smoke_cmp) begin
                    s_nxt.mode = ST_ALRM; // [RL2] [RL6] [RL12]
                    s_nxt.horn_ph = '0;
                end else if (io_in && at_end(s_r.io_cnt, P_CYC_IODLY)) begin
                    s_nxt.mode = ST_REMT; // [RL14]
                    s_nxt.horn_ph = '0;
                end
            end
            ST_ALRM: begin
                if (strb_end && !smoke_cmp
                    && s_r.horn_ph >= 3'(N_HORN_ON)) begin
                    s_nxt.mode = ST_STBY; // [RL8]
                end
            end
            ST_REMT: begin
                if (strb_end && smoke_cmp) begin
                    s_nxt.mode = ST_ALRM; // [RL2]
                end else if (!io_in) begin
                    s_nxt.mode = ST_STBY;
                end
            end
            default: begin
                s_nxt.mode = ST_STBY;
            end
        endcase
        if (alarm) begin
            s_nxt.batt_cnt = '0;
            s_nxt.tled_cnt = '0;
        end

        // Interconnect delay
        if (s_r.mode == ST_STBY && io_in
            && !at_end(s_r.io_cnt, P_CYC_IODLY)) begin
            s_nxt.io_cnt = s_r.io_cnt + 1'b1; // [RL14]
        end else begin
            s_nxt.io_cnt = '0;
        end

        // Hush timer keeps running through an alarm
        if (s_r.timer_mode && slow_tick) begin
            s_nxt.hush_cnt = s_r.hush_cnt - 1'b1; // [RL13]
            if (s_r.hush_cnt == 9'd1) begin
                s_nxt.timer_mode = 1'b0; // [RL20]
                s_nxt.tled_cnt = '0;
            end
        end
        if (hush_fall) begin
            s_nxt.hush_cnt = 9'(N_HUSH); // [RL10]
            s_nxt.timer_mode = 1'b1;
            s_nxt.tled_cnt = '0;
            if (s_r.mode == ST_ALRM) begin
                s_nxt.mode = ST_STBY; // [RL10]
            end
        end

        // Outputs held in flip-flops
        s_nxt.io_drv = (s_nxt.mode == ST_ALRM); // [RL14]
        case (s_nxt.mode)
            ST_ALRM: begin
                s_nxt.led = s_nxt.blink; // [RL9]
                s_nxt.horn = (s_nxt.horn_ph < 3'(N_HORN_ON)); // [RL7]
            end
            ST_REMT: begin
                s_nxt.led = 1'b0; // [RL15]
                s_nxt.horn = (s_nxt.horn_ph < 3'(N_HORN_ON));
            end
            default: begin
                s_nxt.led = s_nxt.lb_pulse; // [RL3] [RL11]
                s_nxt.horn = s_nxt.lb_pulse && s_r.batt_low;
            end
        endcase
        if (s_r.test_mode) begin
            s_nxt.horn = batt_low_cmp; // [RL17]
        end

        // Power-up strap capture
        s_nxt.first = 1'b0;
        if (s_r.first) begin
            s_nxt.test_mode = !test_n && !osc_in; // [RL17]
        end

        // AXI4-Lite write channel
        ctrl_word = '0;
        ctrl_word[CTRL_EXT_OSC] = s_r.ext_osc;
        if (s_axi_awvalid && s_axi_awready) begin
            s_nxt.aw_v = 1'b1;
            s_nxt.aw_a = s_axi_awaddr;
        end
        if (s_axi_wvalid && s_axi_wready) begin
            s_nxt.w_v = 1'b1;
            s_nxt.w_d = merge(ctrl_word, s_axi_wdata, s_axi_wstrb);
        end
        if (s_r.aw_v && s_r.w_v) begin
            s_nxt.aw_v = 1'b0;
            s_nxt.w_v = 1'b0;
            s_nxt.bvalid = 1'b1;
            if (s_r.aw_a == A_CTRL) begin
                s_nxt.ext_osc = s_r.w_d[CTRL_EXT_OSC]; // [RL18]
                s_nxt.bresp = RESP_OKAY;
            end else if (s_r.aw_a == A_STAT) begin
                s_nxt.bresp = RESP_OKAY;
            end else begin
                s_nxt.bresp = RESP_SLVERR;
            end
        end
        if (s_r.bvalid && s_axi_bready) begin
            s_nxt.bvalid = 1'b0;
        end

        // AXI4-Lite read channel
        stat_word = '0;
        stat_word[ST_B_LOCAL] = (s_r.mode == ST_ALRM);
        stat_word[ST_B_REMOTE] = (s_r.mode == ST_REMT);
        stat_word[ST_B_TIMER] = s_r.timer_mode;
        stat_word[ST_B_BATT] = s_r.batt_low;
        stat_word[ST_B_TEST] = s_r.test_mode;
        stat_word[ST_B_HYST] = (s_r.mode == ST_ALRM);
        if (s_axi_arvalid && s_axi_arready) begin
            s_nxt.rvalid = 1'b1;
            s_nxt.rresp = RESP_OKAY;
            if (s_axi_araddr == A_CTRL) begin
                s_nxt.rdata = ctrl_word;
            end else if (s_axi_araddr == A_STAT) begin
                s_nxt.rdata = stat_word;
            end else begin
                s_nxt.rdata = '0;
                s_nxt.rresp = RESP_SLVERR;
            end
        end else if (s_r.rvalid && s_axi_rready) begin
            s_nxt.rvalid = 1'b0;
        end
    end

    // State register
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_r <= '0; // [RL16]
            s_r.mode <= ST_STBY;
            s_r.first <= 1'b1;
            s_r.ext_osc <= CTRL_RST[CTRL_EXT_OSC];
            s_r.hush_d <= 1'b1;
        end else begin
            s_r <= s_nxt;
        end
    end

    // Bus handshakes
    assign s_axi_awready = !s_r.aw_v && !s_r.bvalid;
    assign s_axi_wready = !s_r.w_v && !s_r.bvalid;
    assign s_axi_bvalid = s_r.bvalid;
    assign s_axi_bresp = s_r.bresp;
    assign s_axi_arready = !s_r.rvalid;
    assign s_axi_rvalid = s_r.rvalid;
    assign s_axi_rdata = s_r.rdata;
    assign s_axi_rresp = s_r.rresp;

    // Pin outputs
    assign strobe = s_r.strb;
    assign hyst_sel = (s_r.mode == ST_ALRM); // [RL5]
    assign reduced_sens = s_r.timer_mode; // [RL10] [RL20]
    assign led_on = s_r.led;
    assign horn_drive_primary = s_r.horn;
    assign osc_fast = (s_r.mode != ST_STBY); // [RL6]
    assign io_out = s_r.io_drv;
    assign io_oe_n = !s_r.io_drv;

endmodule : sas_top
